// >>> hdl/rcr_burst_timer.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Cadence interval timer: prescaler plus step counter
// ---------------------------------------------------------------
module rcr_burst_timer #(
   parameter int TICK = rcr_pkg::TICK_CYCLES,
   parameter int CW = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   input wire logic run,
   input wire logic [CW-1:0] length,
   output logic done
);

   typedef struct packed {
      logic [7:0] pre;
      logic [CW-1:0] cnt;
      logic done;
   } rcr_tmr_t;

   localparam logic [7:0] TICK_LAST = 8'(TICK - 1);

   rcr_tmr_t t_reg;
   rcr_tmr_t t_next;

   // Step counting; a zero length still lasts one step
   always_comb begin
      t_next = t_reg;
      t_next.done = 1'b0;
      if (start) begin
         t_next.pre = 8'h00;
         t_next.cnt = '0;
      end else if (run) begin
         if (t_reg.pre == TICK_LAST) begin
            t_next.pre = 8'h00;
            t_next.cnt = t_reg.cnt + 1'b1;
            if ({1'b0, t_reg.cnt} + 1'b1 >= {1'b0, length}) begin
               t_next.done = 1'b1;
            end
         end else begin
            t_next.pre = t_reg.pre + 8'h01;
         end
      end
   end

   // State register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         t_reg <= '0;
      end else begin
         t_reg <= t_next;
      end
   end

   assign done = t_reg.done;

endmodule

// >>> hdl/rcr_pkg.sv
// ---------------------------------------------------------------
// Shared constants for the ringing cadence and relay control block
// ---------------------------------------------------------------
package rcr_pkg;

   // Register addresses
   localparam logic [7:0] ADDR_RELAY_CFG = 8'h05;
   localparam logic [7:0] ADDR_RING_CFG = 8'h17;
   localparam logic [7:0] ADDR_ON_LOW = 8'h18;
   localparam logic [7:0] ADDR_ON_HIGH = 8'h19;
   localparam logic [7:0] ADDR_OFF_LOW = 8'h1A;
   localparam logic [7:0] ADDR_OFF_HIGH = 8'h1B;

   // Relay and battery configuration fields
   localparam int BIT_BATT_IND = 5;
   localparam int BIT_RAIL = 4;
   localparam int BIT_RELAY_DRIVE_ENABLE = 3;
   localparam int BIT_AUX = 2;
   localparam logic [1:0] RELAY_RSVD_HI = 2'h2;

   // Ringing configuration fields
   localparam int BIT_ON_EN = 4;
   localparam int BIT_OFF_EN = 3;
   localparam int BIT_OSC_MON = 2;

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic RST_BIT = 1'b0;

   // Timing: one count step of either cadence timer
   localparam int LSB_TIME_PS = 1250000;
   localparam int CLK_PERIOD_PS = 10000;
   localparam int TICK_CYCLES = (LSB_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic [1:0] {
      RCR_IDLE,
      RCR_BURST,
      RCR_SILENT
   } rcr_state_t;

endpackage

// >>> hdl/rcr_ring_cadence.sv
`timescale 1ns/100ps
// Notes on behaviour
// - On-time count bits 15..8 live in the register at address 25.
// - On-time bits 7..0 at address 24; each step is 1.25 us.
// - Silent-time count bits 15..8 live in the register at address 27.
// - Silent-time bits 7..0 at address 26; each step is 1.25 us.
// - Battery indicator bit is read only and mirrors the battery switch pin.
// - With third rail present and the drive enable bit set, the relay drive follows the ringing cadence.
// - Relay drive pin is active only while its enable bit is set.
// - Aux output pin follows bit 2 of the relay configuration register.
// - On-time timer ends bursts only while its enable bit is set.
// - Silent-time timer ends silences only while its enable bit is set.
module rcr_ring_cadence #(
   parameter int TICK = rcr_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic ring_request,
   input wire logic battery_switch_pin,
   output logic ring_osc_enable,
   output logic relay_drive_pin,
   output logic aux_output_pin
);

   typedef struct packed {
      rcr_pkg::rcr_state_t state;
      logic [15:0] burst_on_count;
      logic [15:0] burst_off_count;
      logic third_rail_present;
      logic relay_drive_enable;
      logic aux_level;
      logic on_timer_enable;
      logic off_timer_enable;
      logic timer_start;
      logic [7:0] rdata;
      logic rvalid;
      logic osc;
      logic relay;
      logic aux;
   } rcr_state_vec_t;

   rcr_state_vec_t s_reg;
   rcr_state_vec_t s_next;
   logic timer_done;
   logic timer_run;
   logic [15:0] timer_len;

   // ---------------------------------------------------------------
   // Interval timer
   // ---------------------------------------------------------------

   // One shared timer is enough: burst and silence never overlap
   assign timer_len = (s_reg.state == rcr_pkg::RCR_BURST) ? s_reg.burst_on_count : s_reg.burst_off_count;
   assign timer_run = ((s_reg.state == rcr_pkg::RCR_BURST) && s_reg.on_timer_enable) ||
                      ((s_reg.state == rcr_pkg::RCR_SILENT) && s_reg.off_timer_enable);

   rcr_burst_timer #(
      .TICK(TICK),
      .CW(16)
   ) u_timer (
      .clk(clk),
      .reset(reset),
      .start(s_reg.timer_start),
      .run(timer_run),
      .length(timer_len),
      .done(timer_done)
   );

   // ---------------------------------------------------------------
   // Register port, cadence sequencer and pin drivers
   // ---------------------------------------------------------------

   // Next-state logic for the whole block
   always_comb begin
      s_next = s_reg;
      s_next.timer_start = 1'b0;
      s_next.rvalid = reg_rd;
      s_next.rdata = 8'h00;
      // Register writes; unmapped addresses are ignored
      if (reg_wr) begin
         if (reg_addr == rcr_pkg::ADDR_RELAY_CFG) begin
            s_next.third_rail_present = reg_wdata[rcr_pkg::BIT_RAIL];
            s_next.relay_drive_enable = reg_wdata[rcr_pkg::BIT_RELAY_DRIVE_ENABLE];
            s_next.aux_level = reg_wdata[rcr_pkg::BIT_AUX];
         end else if (reg_addr == rcr_pkg::ADDR_RING_CFG) begin
            s_next.on_timer_enable = reg_wdata[rcr_pkg::BIT_ON_EN];
            s_next.off_timer_enable = reg_wdata[rcr_pkg::BIT_OFF_EN];
         end else if (reg_addr == rcr_pkg::ADDR_ON_LOW) begin
            s_next.burst_on_count[7:0] = reg_wdata;
         end else if (reg_addr == rcr_pkg::ADDR_ON_HIGH) begin
            s_next.burst_on_count[15:8] = reg_wdata;
         end else if (reg_addr == rcr_pkg::ADDR_OFF_LOW) begin
            s_next.burst_off_count[7:0] = reg_wdata;
         end else if (reg_addr == rcr_pkg::ADDR_OFF_HIGH) begin
            s_next.burst_off_count[15:8] = reg_wdata;
         end
      end
      // Register reads; unmapped addresses return zero
      if (reg_rd) begin
         if (reg_addr == rcr_pkg::ADDR_RELAY_CFG) begin
            s_next.rdata[7:6] = rcr_pkg::RELAY_RSVD_HI;
            s_next.rdata[rcr_pkg::BIT_BATT_IND] = battery_switch_pin;
            s_next.rdata[rcr_pkg::BIT_RAIL] = s_reg.third_rail_present;
            s_next.rdata[rcr_pkg::BIT_RELAY_DRIVE_ENABLE] = s_reg.relay_drive_enable;
            s_next.rdata[rcr_pkg::BIT_AUX] = s_reg.aux_level;
         end else if (reg_addr == rcr_pkg::ADDR_RING_CFG) begin
            s_next.rdata[rcr_pkg::BIT_ON_EN] = s_reg.on_timer_enable;
            s_next.rdata[rcr_pkg::BIT_OFF_EN] = s_reg.off_timer_enable;
            s_next.rdata[rcr_pkg::BIT_OSC_MON] = s_reg.osc;
         end else if (reg_addr == rcr_pkg::ADDR_ON_LOW) begin
            s_next.rdata = s_reg.burst_on_count[7:0];
         end else if (reg_addr == rcr_pkg::ADDR_ON_HIGH) begin
            s_next.rdata = s_reg.burst_on_count[15:8];
         end else if (reg_addr == rcr_pkg::ADDR_OFF_LOW) begin
            s_next.rdata = s_reg.burst_off_count[7:0];
         end else if (reg_addr == rcr_pkg::ADDR_OFF_HIGH) begin
            s_next.rdata = s_reg.burst_off_count[15:8];
         end
      end
      case (s_reg.state)
         rcr_pkg::RCR_IDLE: begin
            if (ring_request) begin
               s_next.state = rcr_pkg::RCR_BURST;
               s_next.timer_start = 1'b1;
            end
         end
         rcr_pkg::RCR_BURST: begin
            if (!ring_request) begin
               s_next.state = rcr_pkg::RCR_IDLE;
            end else if (timer_done) begin
               s_next.state = rcr_pkg::RCR_SILENT;
               s_next.timer_start = 1'b1;
            end
         end
         rcr_pkg::RCR_SILENT: begin
            if (!ring_request) begin
               s_next.state = rcr_pkg::RCR_IDLE;
            end else if (timer_done) begin
               s_next.state = rcr_pkg::RCR_BURST;
               s_next.timer_start = 1'b1;
            end
         end
         default: begin
            s_next.state = rcr_pkg::RCR_IDLE;
         end
      endcase
      s_next.osc = (s_next.state == rcr_pkg::RCR_BURST);
      // relay gated by rail and enable
      s_next.relay = s_next.relay_drive_enable && s_next.third_rail_present && s_next.osc;
      s_next.aux = s_next.aux_level;
   end

   // State register; every output comes from here
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_reg <= '0;
         s_reg.state <= rcr_pkg::RCR_IDLE;
         s_reg.burst_on_count <= {rcr_pkg::RST_BYTE, rcr_pkg::RST_BYTE};
         s_reg.burst_off_count <= {rcr_pkg::RST_BYTE, rcr_pkg::RST_BYTE};
         s_reg.relay_drive_enable <= rcr_pkg::RST_BIT;
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata = s_reg.rdata;
   assign reg_rvalid = s_reg.rvalid;
   assign ring_osc_enable = s_reg.osc;
   assign relay_drive_pin = s_reg.relay;
   assign aux_output_pin = s_reg.aux;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   property p_on_high;
      (reg_wr && reg_addr == rcr_pkg::ADDR_ON_HIGH) |=> s_reg.burst_on_count[15:8] == $past(reg_wdata);
   endproperty
   a_on_high: assert property (p_on_high) else $error("on-time high byte not stored");

   property p_on_low;
      (reg_wr && reg_addr == rcr_pkg::ADDR_ON_LOW) |=> s_reg.burst_on_count[7:0] == $past(reg_wdata);
   endproperty
   a_on_low: assert property (p_on_low) else $error("on-time low byte not stored");

   property p_off_high;
      (reg_wr && reg_addr == rcr_pkg::ADDR_OFF_HIGH) |=> s_reg.burst_off_count[15:8] == $past(reg_wdata);
   endproperty
   a_off_high: assert property (p_off_high) else $error("silent high byte not stored");

   property p_off_low;
      (reg_wr && reg_addr == rcr_pkg::ADDR_OFF_LOW) |=> s_reg.burst_off_count[7:0] == $past(reg_wdata);
   endproperty
   a_off_low: assert property (p_off_low) else $error("silent low byte not stored");

   property p_batt_ind;
      (reg_rd && reg_addr == rcr_pkg::ADDR_RELAY_CFG) |=>
         reg_rdata[rcr_pkg::BIT_BATT_IND] == $past(battery_switch_pin) && reg_rdata[7:6] == 2'h2;
   endproperty
   a_batt_ind: assert property (p_batt_ind) else $error("battery indicator wrong");

   property p_rail;
      relay_drive_pin |-> s_reg.third_rail_present && ring_osc_enable;
   endproperty
   a_rail: assert property (p_rail) else $error("relay active outside burst or without rail");

   property p_relay_drive_enable;
      !s_reg.relay_drive_enable |-> !relay_drive_pin;
   endproperty
   a_relay_drive_enable: assert property (p_relay_drive_enable) else $error("relay active while disabled");

   property p_aux;
      (reg_wr && reg_addr == rcr_pkg::ADDR_RELAY_CFG) |=> aux_output_pin == $past(reg_wdata[2]);
   endproperty
   a_aux: assert property (p_aux) else $error("aux pin does not follow bit");

   property p_on_hold;
      (s_reg.state == rcr_pkg::RCR_BURST && !s_reg.on_timer_enable && ring_request) |=>
         s_reg.state == rcr_pkg::RCR_BURST;
   endproperty
   a_on_hold: assert property (p_on_hold) else $error("burst ended with on timer disabled");

   property p_off_hold;
      (s_reg.state == rcr_pkg::RCR_SILENT && !s_reg.off_timer_enable && ring_request) |=>
         s_reg.state == rcr_pkg::RCR_SILENT;
   endproperty
   a_off_hold: assert property (p_off_hold) else $error("silence ended with off timer disabled");

   property p_alternate;
      (s_reg.state == rcr_pkg::RCR_BURST && timer_done && ring_request) |=>
         !ring_osc_enable ##0 $fell(ring_osc_enable);
   endproperty
   a_alternate: assert property (p_alternate) else $error("burst did not give way to silence");

endmodule

// >>> tb/rcr_line_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Linefeed driver and relay stand-in
// ---------------------------------------------------------------
module rcr_line_model (
   input wire logic clk,
   input wire logic set_battery,
   input wire logic relay_drive_pin,
   output logic battery_switch_pin,
   output int relay_pulses
);
   logic relay_q;
   initial begin
      battery_switch_pin = 1'b0;
      relay_q = 1'b0;
      relay_pulses = 0;
   end
   always @(posedge clk) battery_switch_pin <= set_battery;
   // count relay closures, one per burst
   always @(posedge clk) begin
      relay_q <= relay_drive_pin;
      if (relay_drive_pin === 1'b1 && relay_q === 1'b0) relay_pulses <= relay_pulses + 1;
   end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Cadence and relay control bench
// ---------------------------------------------------------------
module tb_top;
   localparam int TK = 2; // Short step keeps 16-bit counts cheap
   logic clk, reset, reg_wr, reg_rd, ring_request, set_batt, mon_relay, rail_on;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
   logic reg_rvalid, ring_osc_enable, relay_drive_pin, aux_output_pin, battery_switch_pin;
   int n_mismatch, cmp_count, cyc, n, relay_pulses, p0;

   rcr_ring_cadence #(.TICK(TK)) DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .ring_request(ring_request), .battery_switch_pin(battery_switch_pin),
      .ring_osc_enable(ring_osc_enable), .relay_drive_pin(relay_drive_pin), .aux_output_pin(aux_output_pin));
   rcr_line_model LINE (.clk(clk), .set_battery(set_batt), .relay_drive_pin(relay_drive_pin),
      .battery_switch_pin(battery_switch_pin), .relay_pulses(relay_pulses));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         final_report();
      end
   end

   // relay follows burst only when armed
   always @(negedge clk) if (mon_relay) chk(relay_drive_pin, ring_osc_enable & rail_on);

   task chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task final_report();
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read answer stands one cycle after the strobe edge
   task rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rvalid, 1'b1);
      chk(reg_rdata, exp);
   endtask

   // Length in cycles of the next stretch at level lvl
   task span(input logic lvl);
      int k;
      k = 0;
      n = 0;
      while (ring_osc_enable !== lvl && k < 3000) begin
         @(posedge clk);
         #1 k++;
      end
      while (ring_osc_enable === lvl && n < 3000) begin
         @(posedge clk);
         #1 n++;
      end
   endtask

   task stop_ring();
      @(posedge clk);
      ring_request <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk(ring_osc_enable, 1'b0);
   endtask

   task t_regs();
      rdchk(8'h40, 8'h00);
      rdchk(8'h17, 8'h00);
      rdchk(8'h18, 8'h00);
      rdchk(8'h19, 8'h00);
      rdchk(8'h1A, 8'h00);
      rdchk(8'h1B, 8'h00);
      rdchk(8'h05, 8'h80);
      wr(8'h18, 8'hA5);
      wr(8'h19, 8'h5A);
      wr(8'h1A, 8'hC3);
      wr(8'h1B, 8'h3C);
      wr(8'h05, 8'hFF);
      rdchk(8'h18, 8'hA5);
      rdchk(8'h19, 8'h5A);
      rdchk(8'h1A, 8'hC3);
      rdchk(8'h1B, 8'h3C);
      rdchk(8'h05, 8'h9C);
      chk(aux_output_pin, 1'b1);
      wr(8'h05, 8'h00);
      #1 chk(aux_output_pin, 1'b0);
      @(posedge clk);
      set_batt <= 1'b1;
      repeat (3) @(posedge clk);
      rdchk(8'h05, 8'hA0);
      @(posedge clk);
      set_batt <= 1'b0;
      repeat (3) @(posedge clk);
      rdchk(8'h05, 8'h80);
   endtask

   // Burst, silence, burst with given counts, relay armed by cfg
   task t_cadence(input logic [15:0] on_n, input logic [15:0] off_n, input logic [7:0] cfg);
      wr(8'h18, on_n[7:0]);
      wr(8'h19, on_n[15:8]);
      wr(8'h1A, off_n[7:0]);
      wr(8'h1B, off_n[15:8]);
      wr(8'h17, 8'h18);
      wr(8'h05, cfg);
      rail_on = (cfg == 8'h18);
      mon_relay = 1'b1;
      p0 = relay_pulses;
      ring_request <= 1'b1;
      span(1'b1);
      chk(n >= on_n * TK && n <= on_n * TK + 2, 1'b1);
      span(1'b0);
      chk(n >= off_n * TK && n <= off_n * TK + 2, 1'b1);
      span(1'b1);
      chk(n >= on_n * TK && n <= on_n * TK + 2, 1'b1);
      stop_ring();
      mon_relay = 1'b0;
      chk(relay_pulses - p0, rail_on ? 16'h0002 : 16'h0000);
   endtask

   task t_timers_off();
      wr(8'h18, 8'h03);
      wr(8'h19, 8'h00);
      wr(8'h17, 8'h08);
      ring_request <= 1'b1;
      repeat (300) @(posedge clk);
      #1 chk(ring_osc_enable, 1'b1);
      rdchk(8'h17, 8'h0C);
      stop_ring();
      wr(8'h17, 8'h10);
      ring_request <= 1'b1;
      span(1'b1);
      repeat (300) @(posedge clk);
      #1 chk(ring_osc_enable, 1'b0);
      rdchk(8'h17, 8'h10);
      stop_ring();
   endtask

   initial begin
      reset = 1'b1;
      {reg_wr, reg_rd, ring_request, set_batt, mon_relay, rail_on} = '0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_cadence(16'h0003, 16'h0002, 8'h18);
      t_cadence(16'h0100, 16'h0100, 8'h18);
      t_cadence(16'h0003, 16'h0002, 8'h10);
      t_cadence(16'h0003, 16'h0002, 8'h08);
      t_timers_off();
      final_report();
   end
endmodule
